// ==== core/frtc_consts.svh ====
// constants for the free-running timer, capture units, interrupt gating and watchdog
// Functional notes
// - 12-bit counter steps at 1 MHz, always
// - periodic taps at 128 us and 1.024 ms
// - counter value readable for duration measurement
// - selected pin edge latches 8-bit counter window
// - two pins, two 8-bit capture registers each
// - one register rising-only, other falling-only
// - five prescaler settings choose capture resolution
// - each capture store raises its interrupt
// - ten maskable interrupt sources in controller
// - watchdog resets device after about 8 ms
// - first pin feeds unit A, second B
`ifndef FRTC_CONSTS_SVH
`define FRTC_CONSTS_SVH

// ==================================================
// clocking
`define FRTC_CLOCK_HZ 20000000
`define FRTC_TICK_HZ 1000000
`define FRTC_TICK_DIV (`FRTC_CLOCK_HZ / `FRTC_TICK_HZ)
`define FRTC_DIV_W 5

// ==================================================
// free-running counter and taps
`define FRTC_COUNT_W 12
`define FRTC_COUNT_RESET 12'h000
`define FRTC_FAST_TAP_US 128
`define FRTC_SLOW_TAP_US 1024
`define FRTC_FAST_TAP_TICKS (`FRTC_FAST_TAP_US * (`FRTC_TICK_HZ / 1000000))
`define FRTC_SLOW_TAP_TICKS (`FRTC_SLOW_TAP_US * (`FRTC_TICK_HZ / 1000000))
`define FRTC_FAST_TAP_BITS $clog2(`FRTC_FAST_TAP_TICKS)
`define FRTC_SLOW_TAP_BITS $clog2(`FRTC_SLOW_TAP_TICKS)

// ==================================================
// capture
`define FRTC_CAPT_W 8
`define FRTC_CAPT_RESET 8'h00
`define FRTC_SCALE_W 3
`define FRTC_SCALE_MAX 3'h4
`define FRTC_EDGE_RISE 0
`define FRTC_EDGE_FALL 1

// ==================================================
// interrupt source positions
`define FRTC_IRQ_N 10
`define FRTC_IRQ_BUSRST 0
`define FRTC_IRQ_FAST 1
`define FRTC_IRQ_SLOW 2
`define FRTC_IRQ_EP0 3
`define FRTC_IRQ_CAPTA 6
`define FRTC_IRQ_CAPTB 7
`define FRTC_IRQ_WAKE 8
`define FRTC_IRQ_GPIO 9
`define FRTC_IRQ_RESET 10'h000

// ==================================================
// watchdog
`define FRTC_WDOG_MS 8
`define FRTC_WDOG_CYCLES ((`FRTC_WDOG_MS * `FRTC_CLOCK_HZ) / 1000)

`endif

// ==== core/frtc_pkg.sv ====
// types shared by the timer and capture modules
package frtc_pkg;
	typedef logic [11:0] frtc_count_t; // free-running counter value
	typedef logic [7:0] frtc_capt_t; // captured window
	typedef logic [2:0] frtc_scale_t; // prescaler setting
	typedef logic [1:0] frtc_edge_t; // edge enables: bit0 rising, bit1 falling
	typedef logic [9:0] frtc_irq_t; // one bit per interrupt source
endpackage

// ==== core/frtc_capture_unit.sv ====
// one capture unit: pin synchroniser, edge detect, rising and falling capture registers
`timescale 1ns/1ns
`include "frtc_consts.svh"
module frtc_capture_unit
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic capturePin,
	input wire frtc_pkg::frtc_count_t timerCount,
	input wire frtc_pkg::frtc_scale_t captureScale,
	input wire frtc_pkg::frtc_edge_t edgeEnable,
	output frtc_pkg::frtc_capt_t riseValue,
	output frtc_pkg::frtc_capt_t fallValue,
	output logic captIrq
);
	import frtc_pkg::*;

	// ==================================================
	// window selection
	// settings above the last one clamp to it, so a bad value never reads past the top bit
	function automatic frtc_capt_t windowOf(input frtc_count_t cnt, input frtc_scale_t sel);
		frtc_scale_t s;
		frtc_count_t shifted;
		s = (sel > `FRTC_SCALE_MAX) ? `FRTC_SCALE_MAX : sel;
		shifted = cnt >> s;
		return shifted[`FRTC_CAPT_W-1:0];
	endfunction

	// ==================================================
	// pin synchroniser
	logic pinSync1_q; // first stage, read only by the second
	logic pinSync2_q; // second stage
	logic pinSync3_q; // third stage, compared with second
	logic riseSeen; // agreed rising change
	logic fallSeen; // agreed falling change
	frtc_capt_t window; // current counter slice
	frtc_capt_t riseValue_q;
	frtc_capt_t fallValue_q;
	logic captIrq_q;

	// two flops before any edge logic looks at the pin; the third holds the previous sample
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
			pinSync3_q <= 1'b0;
		end
		else
		begin
			pinSync1_q <= capturePin;
			pinSync2_q <= pinSync1_q;
			pinSync3_q <= pinSync2_q;
		end
	end

	assign riseSeen = pinSync2_q && !pinSync3_q && edgeEnable[`FRTC_EDGE_RISE];
	assign fallSeen = !pinSync2_q && pinSync3_q && edgeEnable[`FRTC_EDGE_FALL];
	assign window = windowOf(timerCount, captureScale);

	// ==================================================
	// capture registers
	// rising register only on rising edges
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			riseValue_q <= `FRTC_CAPT_RESET;
		else if (riseSeen)
			riseValue_q <= window;
	end

	// falling register only on falling edges
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			fallValue_q <= `FRTC_CAPT_RESET;
		else if (fallSeen)
			fallValue_q <= window;
	end

	// one-cycle interrupt pulse whenever a value was stored
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			captIrq_q <= 1'b0;
		else
			captIrq_q <= riseSeen || fallSeen;
	end

	assign riseValue = riseValue_q;
	assign fallValue = fallValue_q;
	assign captIrq = captIrq_q;

	// ==================================================
	// checks
	AST_RISE_LOAD: assert property (@(posedge clock) disable iff (!resetn)
		riseSeen |=> (riseValue_q == $past(window)) && captIrq_q)
		else $error("rising capture not stored");
	AST_FALL_KEEPS_RISE: assert property (@(posedge clock) disable iff (!resetn)
		(fallSeen && !riseSeen) |=> $stable(riseValue_q))
		else $error("falling edge touched rising register");
	AST_FALL_LOAD: assert property (@(posedge clock) disable iff (!resetn)
		fallSeen |=> (fallValue_q == $past(window)) && captIrq_q)
		else $error("falling capture not stored");
	AST_IRQ_CAUSE: assert property (@(posedge clock) disable iff (!resetn)
		captIrq_q |-> ($past(riseSeen) || $past(fallSeen)))
		else $error("capture interrupt without edge");
	COV_RISE: cover property (@(posedge clock) disable iff (!resetn) riseSeen);
	COV_FALL: cover property (@(posedge clock) disable iff (!resetn) fallSeen);
endmodule

// ==== core/frtc_timer_capture.sv ====
// free-running timer with taps, two capture units, interrupt gating and watchdog
`timescale 1ns/1ns
`include "frtc_consts.svh"
module frtc_timer_capture
#(
	parameter int WDOG_CYCLES = `FRTC_WDOG_CYCLES
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic capturePinFirst,
	input wire logic capturePinSecond,
	input wire frtc_pkg::frtc_scale_t captureScale,
	input wire frtc_pkg::frtc_edge_t captAEdge,
	input wire frtc_pkg::frtc_edge_t captBEdge,
	input wire logic busResetEvent,
	input wire logic [2:0] endpointEvent,
	input wire logic wakeupEvent,
	input wire logic gpioEvent,
	input wire frtc_pkg::frtc_irq_t irqEnable,
	input wire frtc_pkg::frtc_irq_t irqAck,
	input wire logic watchdogKick,
	output frtc_pkg::frtc_count_t timerValue,
	output logic fastTapIrq,
	output logic slowTapIrq,
	output frtc_pkg::frtc_capt_t captARise,
	output frtc_pkg::frtc_capt_t captAFall,
	output frtc_pkg::frtc_capt_t captBRise,
	output frtc_pkg::frtc_capt_t captBFall,
	output logic captAIrq,
	output logic captBIrq,
	output frtc_pkg::frtc_irq_t irqPending,
	output logic irqRequest,
	output logic watchdogReset
);
	import frtc_pkg::*;

	localparam int WdogW = $clog2(WDOG_CYCLES + 1);
	localparam int WdogLast = WDOG_CYCLES - 1;
	localparam int TickLast = `FRTC_TICK_DIV - 1;

	// ==================================================
	// 1 MHz time base
	logic [`FRTC_DIV_W-1:0] divCount_q; // clocks within one microsecond
	logic tick; // one-cycle enable at 1 MHz

	// divider runs from reset on, never waits for firmware
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			divCount_q <= '0;
		else if (tick)
			divCount_q <= '0;
		else
			divCount_q <= divCount_q + 1'b1;
	end

	assign tick = (divCount_q == `FRTC_DIV_W'(TickLast));

	// ==================================================
	// free-running counter and taps
	frtc_count_t timerCount_q; // readable counter
	logic fastTapIrq_q;
	logic slowTapIrq_q;
	logic fastCarry; // low tap bits about to roll over
	logic slowCarry;

	// wraps from all ones to zero on its own width
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			timerCount_q <= `FRTC_COUNT_RESET;
		else if (tick)
			timerCount_q <= timerCount_q + 1'b1;
	end

	// taps come from the carry out of the low bits, not a separate counter
	assign fastCarry = tick && (&timerCount_q[`FRTC_FAST_TAP_BITS-1:0]);
	assign slowCarry = tick && (&timerCount_q[`FRTC_SLOW_TAP_BITS-1:0]);

	// tap pulses, each only while its enable is set
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			fastTapIrq_q <= 1'b0;
			slowTapIrq_q <= 1'b0;
		end
		else
		begin
			fastTapIrq_q <= fastCarry && irqEnable[`FRTC_IRQ_FAST];
			slowTapIrq_q <= slowCarry && irqEnable[`FRTC_IRQ_SLOW];
		end
	end

	assign timerValue = timerCount_q;
	assign fastTapIrq = fastTapIrq_q;
	assign slowTapIrq = slowTapIrq_q;

	// ==================================================
	// capture units, first pin to A, second to B
	logic [1:0] unitPin; // per-unit pin
	frtc_edge_t unitEdge [2]; // per-unit edge enables
	frtc_capt_t unitRise [2];
	frtc_capt_t unitFall [2];
	logic [1:0] unitIrq;

	assign unitPin = {capturePinSecond, capturePinFirst};
	assign unitEdge[0] = captAEdge;
	assign unitEdge[1] = captBEdge;

	// two identical units, each with its own register pair
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : gUnit
			frtc_capture_unit uCapt
			(
				.clock(clock),
				.resetn(resetn),
				.capturePin(unitPin[gi]),
				.timerCount(timerCount_q),
				.captureScale(captureScale),
				.edgeEnable(unitEdge[gi]),
				.riseValue(unitRise[gi]),
				.fallValue(unitFall[gi]),
				.captIrq(unitIrq[gi])
			);
		end
	endgenerate

	assign captARise = unitRise[0];
	assign captAFall = unitFall[0];
	assign captBRise = unitRise[1];
	assign captBFall = unitFall[1];
	assign captAIrq = unitIrq[0];
	assign captBIrq = unitIrq[1];

	// ==================================================
	// ten-source maskable interrupt gating
	frtc_irq_t irqSource; // raw events this cycle
	frtc_irq_t irqPending_q; // sticky pending flags

	always_comb
	begin
		irqSource = `FRTC_IRQ_RESET;
		irqSource[`FRTC_IRQ_BUSRST] = busResetEvent;
		irqSource[`FRTC_IRQ_FAST] = fastTapIrq_q;
		irqSource[`FRTC_IRQ_SLOW] = slowTapIrq_q;
		irqSource[`FRTC_IRQ_EP0 +: 3] = endpointEvent;
		irqSource[`FRTC_IRQ_CAPTA] = unitIrq[0];
		irqSource[`FRTC_IRQ_CAPTB] = unitIrq[1];
		irqSource[`FRTC_IRQ_WAKE] = wakeupEvent;
		irqSource[`FRTC_IRQ_GPIO] = gpioEvent;
	end

	// a new event in the acknowledge cycle keeps its flag set
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			irqPending_q <= `FRTC_IRQ_RESET;
		else
			irqPending_q <= (irqPending_q & ~irqAck) | irqSource;
	end

	assign irqPending = irqPending_q;
	assign irqRequest = |(irqPending_q & irqEnable);

	// ==================================================
	// watchdog
	logic [WdogW-1:0] wdogCount_q; // cycles since last kick or expiry
	logic watchdogReset_q;
	logic wdogExpire;

	assign wdogExpire = (wdogCount_q == WdogW'(WdogLast));

	// restarts on a kick or after firing, so the reset pulse repeats if firmware stays stalled
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			wdogCount_q <= '0;
		else if (watchdogKick || wdogExpire)
			wdogCount_q <= '0;
		else
			wdogCount_q <= wdogCount_q + 1'b1;
	end

	// one-cycle reset request on expiry
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			watchdogReset_q <= 1'b0;
		else
			watchdogReset_q <= wdogExpire && !watchdogKick;
	end

	assign watchdogReset = watchdogReset_q;

	// ==================================================
	// checks
	AST_TICK_SPACING: assert property (@(posedge clock) disable iff (!resetn)
		tick |=> !tick [*8])
		else $error("time base ticks too close");
	AST_COUNT_STEP: assert property (@(posedge clock) disable iff (!resetn)
		tick |=> timerCount_q == $past(timerCount_q) + 12'h001)
		else $error("counter did not step by one");
	AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (!resetn)
		!tick |=> $stable(timerCount_q))
		else $error("counter moved without tick");
	AST_FAST_TAP: assert property (@(posedge clock) disable iff (!resetn)
		fastTapIrq_q |-> (timerCount_q[6:0] == 7'h00) && $past(irqEnable[`FRTC_IRQ_FAST]))
		else $error("fast tap at wrong count");
	AST_SLOW_TAP: assert property (@(posedge clock) disable iff (!resetn)
		(slowCarry && irqEnable[`FRTC_IRQ_SLOW]) |=> slowTapIrq_q && (timerCount_q[9:0] == 10'h000))
		else $error("slow tap missed");
	AST_IRQ_SET_WINS: assert property (@(posedge clock) disable iff (!resetn)
		1'b1 |=> ((irqPending_q & $past(irqSource)) == $past(irqSource)))
		else $error("interrupt event lost");
	AST_IRQ_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
		1'b1 |=> ((irqPending_q & $past(irqAck) & ~$past(irqSource)) == 10'h000))
		else $error("acknowledged flag stayed set");
	AST_WDOG_FIRE: assert property (@(posedge clock) disable iff (!resetn)
		watchdogReset_q |-> $past(wdogCount_q) == WdogW'(WdogLast))
		else $error("watchdog fired early");
	AST_WDOG_KICK: assert property (@(posedge clock) disable iff (!resetn)
		watchdogKick |=> !watchdogReset_q)
		else $error("watchdog fired after kick");
	COV_FAST: cover property (@(posedge clock) disable iff (!resetn) fastTapIrq_q);
	COV_SLOW: cover property (@(posedge clock) disable iff (!resetn) slowTapIrq_q);
	COV_WDOG: cover property (@(posedge clock) disable iff (!resetn) watchdogReset_q);
endmodule

// ==== dv/frtc_pin_model.sv ====
// far-side model: the two capture pin sources, moving on their own time
`timescale 1ns/1ns
module frtc_pin_model
(
	input wire logic [1:0] pinWant,
	input wire logic [7:0] lagNs,
	output logic capturePinFirst,
	output logic capturePinSecond
);
	// =========================================
	// pin drivers
	// pins start low so the first requested move is a real edge
	initial
	begin
		capturePinFirst = 1'h0;
		capturePinSecond = 1'h0;
	end
	// lag is unrelated to the clock, so the sampling phase varies as on a real pin
	always @(pinWant)
	begin
		capturePinFirst <= #(lagNs) pinWant[0];
		capturePinSecond <= #(lagNs) pinWant[1];
	end
endmodule

// ==== dv/tb_free_running_timer_capture.sv ====
// self-checking bench for the free-running timer, captures, interrupt flags and watchdog
`timescale 1ns/1ns
module tb_free_running_timer_capture;
	import frtc_pkg::*;
	// =========================================
	// signals
	localparam int WDOG = 50; // short watchdog span keeps the run brief
	logic clock, resetn, capturePinFirst, capturePinSecond, watchdogKick;
	logic [1:0] pinWant;
	logic [7:0] lagNs;
	frtc_scale_t captureScale;
	frtc_edge_t captAEdge, captBEdge;
	frtc_irq_t srcV, irqEnable, irqAck, irqPending;
	frtc_count_t timerValue;
	frtc_capt_t captARise, captAFall, captBRise, captBFall;
	logic fastTapIrq, slowTapIrq, captAIrq, captBIrq, irqRequest, watchdogReset;
	int nFail, checks, edges;
	logic [31:0] lfsrQ;
	frtc_capt_t mRise [2]; // bench copy of each unit's rising register
	frtc_capt_t mFall [2]; // bench copy of each unit's falling register
	// =========================================
	// instances
	frtc_pin_model pin_u (.pinWant, .lagNs, .capturePinFirst, .capturePinSecond);
	frtc_timer_capture #(.WDOG_CYCLES(WDOG)) dut_u (.clock, .resetn, .capturePinFirst,
		.capturePinSecond, .captureScale, .captAEdge, .captBEdge, .busResetEvent(srcV[0]),
		.endpointEvent(srcV[5:3]), .wakeupEvent(srcV[8]), .gpioEvent(srcV[9]), .irqEnable,
		.irqAck, .watchdogKick, .timerValue, .fastTapIrq, .slowTapIrq, .captARise, .captAFall,
		.captBRise, .captBFall, .captAIrq, .captBIrq, .irqPending, .irqRequest, .watchdogReset);
	// =========================================
	// reference and helpers
	// edges since reset release; the timer ticks on every twentieth
	always @(posedge clock or negedge resetn)
		if (!resetn)
			edges <= 0;
		else
			edges <= edges + 1;
	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic frtc_count_t expTimer(input int e);
		return frtc_count_t'(e / 20); // cast wraps at 12 bits
	endfunction
	function automatic frtc_capt_t expWin(input frtc_count_t t, input frtc_scale_t s);
		return frtc_capt_t'(t >> ((s > 3'h4) ? 3'h4 : s)); // settings above four clamp
	endfunction
	task automatic chkWord(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp)
		begin
			nFail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkBit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			nFail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (nFail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// =========================================
	// scenario tasks
	// every cycle: counter value and both tap pulses against the edge count
	task automatic tapRun(input int n, input logic en);
		int e;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clock);
			e = edges;
			chkWord("timer", expTimer(e), timerValue);
			chkBit("fastTap", en && e > 0 && e % 2560 == 0, fastTapIrq);
			chkBit("slowTap", en && e > 0 && e % 20480 == 0, slowTapIrq);
		end
	endtask
	// one pin edge; en low arms only the other polarity, so the edge must be ignored
	task automatic capt(input int u, input logic rise, input logic en);
		frtc_capt_t expR, expF;
		logic seen;
		expR = mRise[u];
		expF = mFall[u];
		seen = 1'h0;
		lfsrQ = lfsrNext(lfsrQ);
		@(posedge clock);
		if (u)
			captBEdge <= (rise ^ !en) ? 2'h1 : 2'h2;
		else
			captAEdge <= (rise ^ !en) ? 2'h1 : 2'h2;
		@(posedge clock);
		lagNs <= {1'h0, lfsrQ[6:0]};
		pinWant[u] <= rise;
		for (int i = 0; i < 8 && !seen; i++)
		begin
			@(negedge clock);
			seen = (u ? captBIrq : captAIrq) === 1'h1;
			// stored window comes from the counter in the cycle before the load edge
			if (seen && rise)
				expR = expWin(expTimer(edges - 1), captureScale);
			if (seen && !rise)
				expF = expWin(expTimer(edges - 1), captureScale);
		end
		chkBit("captIrq", en, seen);
		repeat (2) @(negedge clock);
		chkWord("riseReg", {4'h0, expR}, {4'h0, u ? captBRise : captARise});
		chkWord("fallReg", {4'h0, expF}, {4'h0, u ? captBFall : captAFall});
		// a stored capture must also leave its own pending flag set
		if (en)
			chkBit("captPend", 1'h1, irqPending[6 + u]);
		mRise[u] = expR;
		mFall[u] = expF;
		repeat (lfsrQ[12:8]) @(posedge clock);
	endtask
	// source pulse sets its flag; the request follows the enable; ack clears it
	task automatic srcCheck(input int b, input logic en);
		@(posedge clock);
		irqEnable <= frtc_irq_t'(en) << b;
		srcV <= frtc_irq_t'(1) << b;
		@(posedge clock);
		srcV <= 10'h000;
		@(negedge clock);
		chkBit("pending", 1'h1, irqPending[b]);
		chkBit("request", en, irqRequest);
		@(posedge clock);
		irqAck <= frtc_irq_t'(1) << b;
		@(posedge clock);
		irqAck <= 10'h000;
		@(negedge clock);
		chkWord("cleared", 12'h000, {2'h0, irqPending});
	endtask
	// =========================================
	// clock and watchdog on the run
	initial
	begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		repeat (40000) @(posedge clock);
		nFail++;
		tally_and_finish();
	end
	// =========================================
	// main sequence
	initial
	begin
		int mark;
		resetn = 1'h0;
		pinWant = 2'h0;
		lagNs = 8'h00;
		captureScale = 3'h0;
		captAEdge = 2'h0;
		captBEdge = 2'h0;
		srcV = 10'h000;
		irqEnable = 10'h000;
		irqAck = 10'h000;
		watchdogKick = 1'h0;
		nFail = 0;
		checks = 0;
		lfsrQ = 32'h0CDA;
		mRise = '{8'h00, 8'h00};
		mFall = '{8'h00, 8'h00};
		repeat (5) @(posedge clock);
		resetn <= 1'h1;
		irqEnable <= 10'h006;
		tapRun(21000, 1'h1);
		// one idle cycle so a pulse launched under the old enable is not judged
		@(posedge clock);
		irqEnable <= 10'h000;
		@(posedge clock);
		tapRun(2600, 1'h0);
		for (int s = 0; s < 8; s++)
			for (int u = 0; u < 2; u++)
			begin
				@(posedge clock);
				captureScale <= frtc_scale_t'(s);
				capt(u, 1'h1, 1'h1);
				capt(u, 1'h0, 1'h1);
				capt(u, 1'h1, 1'h0);
				capt(u, 1'h0, 1'h0);
			end
		@(posedge clock);
		watchdogKick <= 1'h1;
		@(posedge clock);
		watchdogKick <= 1'h0;
		@(negedge clock);
		mark = edges;
		for (int i = 0; i < 200 && watchdogReset !== 1'h1; i++)
			@(negedge clock);
		chkWord("wdogSpan", 12'(WDOG), 12'(edges - mark));
		repeat (240)
		begin
			@(posedge clock);
			watchdogKick <= (edges % 30 == 0);
			@(negedge clock);
			chkBit("wdogQuiet", 1'h0, watchdogReset);
		end
		@(posedge clock);
		irqAck <= 10'h3FF;
		@(posedge clock);
		irqAck <= 10'h000;
		for (int b = 0; b < 10; b++)
			if (b != 1 && b != 2 && b != 6 && b != 7)
			begin
				lfsrQ = lfsrNext(lfsrQ);
				srcCheck(b, lfsrQ[0]);
				srcCheck(b, !lfsrQ[0]);
			end
		tally_and_finish();
	end
endmodule
